// file: verif/fan_tach_model.sv
`timescale 1ns/1ps
module fan_tach_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Shared drive powering the three fans
  input wire logic drive_in,
  // Tachometer levels
  output logic speed_sense_out2,
  output logic speed_sense_out3,
  output logic speed_sense_out4
);
  logic [7:0] spin_r;
  // Fans turn only while powered, each at its own speed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      spin_r <= 8'h00;
    end else if (drive_in) begin
      spin_r <= spin_r + 8'h01;
    end
  end
  assign speed_sense_out2 = spin_r[2];
  assign speed_sense_out3 = spin_r[3];
  assign speed_sense_out4 = spin_r[4];
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import fan_ramp_pkg::*;
  localparam int SLOT = 8;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic auto_m = 1'b0;
  logic [2:0] below = 3'h0;
  logic [7:0] t1 = 8'h00, t2 = 8'h00, t3 = 8'h00, m1 = 8'h00, m2 = 8'h00, m3 = 8'h00;
  logic s2, s3, s4, d1, d2, d3;
  logic [2:0] sync, pulse;
  int mismatches = 0, compares = 0, cycles = 0;
  int steps [8] = '{1, 2, 3, 5, 8, 12, 24, 48};
  logic [31:0] d;
  logic [1:0] r;
  logic [8:0] n1, n2, n3;
  logic ok;
  logic [2:0] exp_p;
  int bad, slew;

  always #4 clk_in = ~clk_in;

  fan_pwm_acoustic_ramp_ctrl #(.SLOT_CYC(SLOT), .PWM_DIV(1)) i_fan_pwm_acoustic_ramp_ctrl (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .auto_mode_in(auto_m), .below_thresh_in(below),
    .target_duty_in1(t1), .target_duty_in2(t2), .target_duty_in3(t3),
    .min_duty_in1(m1), .min_duty_in2(m2), .min_duty_in3(m3),
    .speed_sense_in2(s2), .speed_sense_in3(s3), .speed_sense_in4(s4),
    .fan_drive_out1(d1), .fan_drive_out2(d2), .fan_drive_out3(d3),
    .sense_sync_out(sync), .sense_pulse_out(pulse)
  );

  fan_tach_model i_fan_tach_model (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .drive_in(d3),
    .speed_sense_out2(s2), .speed_sense_out3(s3), .speed_sense_out4(s4)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // High time of each drive over one full period equals its duty
  task automatic measure();
    n1 = 9'h000;
    n2 = 9'h000;
    n3 = 9'h000;
    repeat (256) begin
      @(posedge clk_in);
      n1 = n1 + {8'h00, d1};
      n2 = n2 + {8'h00, d2};
      n3 = n3 + {8'h00, d3};
    end
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    wait_cyc(5);
    rst_n_in <= 1'b1;
    wait_cyc(1);
    axi_read(CTRL_OFFSET, d, r);
    check("ctrl_reset", d, 32'h0000_0000);
    axi_write(CTRL_OFFSET, 32'hffff_ffa5, r);
    axi_read(CTRL_OFFSET, d, r);
    check("ctrl_rw", {r, d[29:0]}, {2'b00, 30'h0000_00a5});
    axi_write(8'h10, 32'h0000_0001, r);
    check("unmapped_bresp", {30'h0, r}, {30'h0, RESP_DECERR});
    axi_read(8'h10, d, r);
    check("unmapped_read", {r, d[29:0]}, {RESP_DECERR, 30'h0});
    axi_write(STATUS_OFFSET, 32'h0000_00ff, r);
    check("status_wr_resp", {30'h0, r}, {30'h0, RESP_OKAY});
    axi_write(CTRL_OFFSET, 32'h0000_0000, r);
    t1 <= 8'h80;
    wait_cyc(3);
    axi_read(STATUS_OFFSET, d, r);
    check("direct_load", {15'h0, d[16:0]}, 32'h0000_8080);
    for (int c = 0; c < 8; c++) begin
      t1 <= 8'h00;
      axi_write(CTRL_OFFSET, 32'h0000_0000, r);
      wait_cyc(3);
      axi_read(STATUS_OFFSET, d, r);
      check("ramp_off_jump", {24'h0, d[7:0]}, 32'h0);
      axi_write(CTRL_OFFSET, {28'h0, 1'b1, c[2:0]}, r);
      t1 <= 8'hff;
      wait_cyc(3 * SLOT);
      axi_read(STATUS_OFFSET, d, r);
      ok = (int'(d[7:0]) % steps[c] == 0) && (int'(d[7:0]) >= 2 * steps[c]) &&
           (int'(d[7:0]) <= 5 * steps[c]) && d[16];
      check("ramp_mid", {31'h0, ok}, 32'h1);
      wait_cyc(260 * SLOT);
      axi_read(STATUS_OFFSET, d, r);
      check("ramp_end", {15'h0, d[16:0]}, 32'h0000_ffff);
    end
    t1 <= 8'h00;
    wait_cyc(3 * SLOT);
    axi_read(STATUS_OFFSET, d, r);
    ok = ((255 - int'(d[7:0])) % steps[7] == 0) && (255 - int'(d[7:0]) >= 2 * steps[7]) &&
         (255 - int'(d[7:0]) <= 5 * steps[7]) && d[16];
    check("ramp_down_mid", {31'h0, ok}, 32'h1);
    wait_cyc(10 * SLOT);
    axi_read(STATUS_OFFSET, d, r);
    check("ramp_down_end", {15'h0, d[16:0]}, 32'h0);
    auto_m <= 1'b1;
    below <= 3'h7;
    {t1, t2, t3} <= {8'hc0, 8'hc0, 8'hc0};
    {m1, m2, m3} <= {8'h40, 8'h50, 8'h60};
    for (int h = 0; h < 2; h++) begin
      axi_write(CTRL_OFFSET, {24'h0, {3{h[0]}}, 5'h00}, r);
      wait_cyc(4);
      measure();
      check("out1_below", {23'h0, n1}, h ? 32'h40 : 32'h0);
      check("out2_below", {23'h0, n2}, h ? 32'h50 : 32'h0);
      check("out3_below", {23'h0, n3}, h ? 32'h60 : 32'h0);
      axi_read(STATUS_OFFSET, d, r);
      check("eff_target1", {24'h0, d[15:8]}, h ? 32'h40 : 32'h0);
    end
    below <= 3'h0;
    wait_cyc(4);
    measure();
    check("above_thresh", {5'h0, n1, n2, n3}, {5'h0, 9'hc0, 9'hc0, 9'hc0});
    t3 <= 8'h55;
    for (int s = 0; s < 2; s++) begin
      axi_write(CTRL_OFFSET, {27'h0, s[0], 4'h0}, r);
      wait_cyc(2);
      check("sense_sync", {29'h0, sync}, s ? 32'h7 : 32'h6);
      bad = 0;
      exp_p = {s4 && d3, s3 && d3, s2 && (!s[0] || d3)};
      repeat (2048) begin
        @(posedge clk_in);
        if (pulse !== exp_p) bad++;
        exp_p = {s4 && d3, s3 && d3, s2 && (!s[0] || d3)};
      end
      check("sense_pulse", bad, 32'h0);
    end
    slew = int'(DUTY_FULL) - int'(DUTY_FULL) / 3;
    check("slew_slowest", (slew * SLOT_TIME_US + 500_000) / 1_000_000, 32'd35);
    check("slew_fastest", ((slew + steps[7] - 1) / steps[7] * SLOT_TIME_US + 50_000) / 100_000,
          32'd8);
    rst_n_in <= 1'b0;
    wait_cyc(2);
    rst_n_in <= 1'b1;
    wait_cyc(1);
    axi_read(CTRL_OFFSET, d, r);
    check("ctrl_after_reset", d, 32'h0000_0000);
    check("sync_after_reset", {29'h0, sync}, 32'h6);
    print_verdict();
  end
endmodule

// file: verilog/fan_pwm_acoustic_ramp_ctrl.sv
`timescale 1ns/1ps
module fan_pwm_acoustic_ramp_ctrl
  import fan_ramp_pkg::*;
#(
  parameter int SLOT_CYC = SLOT_CYCLES,
  parameter int PWM_DIV = PWM_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Automatic control loop
  input wire logic auto_mode_in,
  input wire logic [2:0] below_thresh_in,
  input wire logic [7:0] target_duty_in1,
  input wire logic [7:0] target_duty_in2,
  input wire logic [7:0] target_duty_in3,
  input wire logic [7:0] min_duty_in1,
  input wire logic [7:0] min_duty_in2,
  input wire logic [7:0] min_duty_in3,
  // Tachometer inputs
  input wire logic speed_sense_in2,
  input wire logic speed_sense_in3,
  input wire logic speed_sense_in4,
  // Fan drives and measurement timing
  output logic fan_drive_out1,
  output logic fan_drive_out2,
  output logic fan_drive_out3,
  output logic [2:0] sense_sync_out,
  output logic [2:0] sense_pulse_out
);

  localparam int SW = $clog2(SLOT_CYC);
  localparam int DW = $clog2(PWM_DIV + 1);

  if (SLOT_CYC < 2 || PWM_DIV < 1) begin : g_bad_param
    $error("SLOT_CYC must be at least 2 and PWM_DIV at least 1");
  end

  // Register bus and control register
  logic [7:0] ctrl_r, ctrl_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // Ramp and drive state
  ramp_state_t state_r, state_nxt;
  logic [7:0] duty1_r, duty1_nxt;
  logic [7:0] tgt_r [3];
  logic [SW-1:0] slot_cnt_r, slot_cnt_nxt;
  logic slot_tick_r, slot_tick_nxt;
  logic [7:0] step_now, up_expect;
  logic [DW-1:0] div_cnt_r, div_cnt_nxt;
  logic [7:0] pwm_cnt_r, pwm_cnt_nxt;
  logic [2:0] pwm_r, pwm_nxt;
  logic [7:0] duty_vec [3];
  logic [7:0] target_vec [3];
  logic [7:0] min_vec [3];
  logic [2:0] hold_vec, sense_vec;

  assign step_now = ramp_step(ctrl_r[RATE_LSB +: 3]);
  assign up_expect = duty1_r + step_now;
  assign target_vec = '{target_duty_in1, target_duty_in2, target_duty_in3};
  assign min_vec = '{min_duty_in1, min_duty_in2, min_duty_in3};
  assign hold_vec = {ctrl_r[HOLD3_BIT], ctrl_r[HOLD2_BIT], ctrl_r[HOLD1_BIT]};
  assign sense_vec = {speed_sense_in4, speed_sense_in3, speed_sense_in2};
  assign duty_vec = '{duty1_r, tgt_r[1], tgt_r[2]};

  always_comb begin
    ctrl_nxt = ctrl_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid_in && awready_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata_in;
      wstrb0_nxt = s_axi_wstrb_in[0];
    end
    if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_got_nxt && w_got_nxt && !bvalid_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (awaddr_nxt[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
        if (wstrb0_nxt) begin
          ctrl_nxt = wdata_nxt[7:0];
        end
      end else if (awaddr_nxt[ADDR_W-1:2] != STATUS_OFFSET[ADDR_W-1:2]) begin
        bresp_nxt = RESP_DECERR;
      end
    end
    if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid_in && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (s_axi_araddr_in[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]) begin
        rdata_nxt[7:0] = ctrl_r;
      end else if (s_axi_araddr_in[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2]) begin
        rdata_nxt[7:0] = duty1_r;
        rdata_nxt[STAT_TARGET_LSB +: 8] = tgt_r[0];
        rdata_nxt[STAT_RAMP_BIT] = (state_r == RAMP_RUN);
      end else begin
        rresp_nxt = RESP_DECERR;
      end
    end
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= CTRL_RESET;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out = wready_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out = rresp_r;
  assign s_axi_rdata_out = rdata_r;

  // Per-output target and tachometer timing
  for (genvar i = 0; i < 3; i++) begin : g_chan
    logic [7:0] tgt_nxt;
    logic sync_r, sync_nxt, pulse_r, pulse_nxt;
    always_comb begin
      tgt_nxt = eff_target(target_vec[i], min_vec[i], hold_vec[i], auto_mode_in,
                           below_thresh_in[i]);
      sync_nxt = (i != 0) || ctrl_r[SYNC_BIT];
      pulse_nxt = sense_vec[i] && (!sync_r || pwm_r[2]);
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        tgt_r[i] <= DUTY_ZERO;
        sync_r <= 1'b0;
        pulse_r <= 1'b0;
      end else begin
        tgt_r[i] <= tgt_nxt;
        sync_r <= sync_nxt;
        pulse_r <= pulse_nxt;
      end
    end
    assign sense_sync_out[i] = sync_r;
    assign sense_pulse_out[i] = pulse_r;
  end

  // Output 1 slew toward its target
  always_comb begin
    slot_tick_nxt = (slot_cnt_r == SW'(SLOT_CYC - 1));
    slot_cnt_nxt = slot_tick_nxt ? '0 : slot_cnt_r + 1'b1;
    duty1_nxt = duty1_r;
    if (!ctrl_r[EN_BIT]) begin
      duty1_nxt = tgt_r[0];
    end else if (slot_tick_r && state_r == RAMP_RUN) begin
      if (tgt_r[0] > duty1_r) begin
        duty1_nxt = (tgt_r[0] - duty1_r > step_now) ? up_expect : tgt_r[0];
      end else begin
        duty1_nxt = (duty1_r - tgt_r[0] > step_now) ? duty1_r - step_now : tgt_r[0];
      end
    end
    state_nxt = (ctrl_r[EN_BIT] && duty1_nxt != tgt_r[0]) ? RAMP_RUN : RAMP_IDLE;
  end

  // Pulse-width generation
  always_comb begin
    div_cnt_nxt = div_cnt_r + 1'b1;
    pwm_cnt_nxt = pwm_cnt_r;
    if (div_cnt_r == DW'(PWM_DIV - 1)) begin
      div_cnt_nxt = '0;
      pwm_cnt_nxt = pwm_cnt_r + 8'h01;
    end
    for (int k = 0; k < 3; k++) begin
      pwm_nxt[k] = (duty_vec[k] == DUTY_FULL) || (pwm_cnt_r < duty_vec[k]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= RAMP_IDLE;
      duty1_r <= DUTY_ZERO;
      slot_cnt_r <= '0;
      slot_tick_r <= 1'b0;
      div_cnt_r <= '0;
      pwm_cnt_r <= 8'h00;
      pwm_r <= 3'b000;
    end else begin
      state_r <= state_nxt;
      duty1_r <= duty1_nxt;
      slot_cnt_r <= slot_cnt_nxt;
      slot_tick_r <= slot_tick_nxt;
      div_cnt_r <= div_cnt_nxt;
      pwm_cnt_r <= pwm_cnt_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  assign fan_drive_out1 = pwm_r[0];
  assign fan_drive_out2 = pwm_r[1];
  assign fan_drive_out3 = pwm_r[2];

  // Checks
  property p_ramp_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    ctrl_r[EN_BIT] && slot_tick_r && state_r == RAMP_RUN && tgt_r[0] > duty1_r
      && (tgt_r[0] - duty1_r) > step_now
      |=> duty1_r - $past(duty1_r) == RAMP_STEPS[$past(ctrl_r[RATE_LSB +: 3])];
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong");

  property p_ramp_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    ctrl_r[EN_BIT] && !slot_tick_r |=> $stable(duty1_r);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("duty moved between slots");

  property p_slot_wrap;
    @(posedge clk_in) disable iff (!rst_n_in)
    slot_tick_r |-> slot_cnt_r == '0 ##1 slot_cnt_r == SW'(1);
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("slot timing wrong");

  property p_direct_load;
    @(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_r[EN_BIT] |=> duty1_r == $past(tgt_r[0]) && state_r == RAMP_IDLE;
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("direct load missed");

  property p_sync_all;
    @(posedge clk_in) disable iff (!rst_n_in)
    ctrl_r[SYNC_BIT] |=> sense_sync_out == 3'b111;
  endproperty
  a_sync_all: assert property (p_sync_all) else $error("sense 2 not synced");

  property p_sync_part;
    @(posedge clk_in) disable iff (!rst_n_in)
    !ctrl_r[SYNC_BIT] |=> sense_sync_out == 3'b110;
  endproperty
  a_sync_part: assert property (p_sync_part) else $error("sense sync wrong");

  property p_floor1;
    @(posedge clk_in) disable iff (!rst_n_in)
    auto_mode_in && below_thresh_in[0]
      |=> tgt_r[0] == ($past(hold_vec[0]) ? $past(min_duty_in1) : DUTY_ZERO);
  endproperty
  a_floor1: assert property (p_floor1) else $error("output 1 floor wrong");

  property p_floor2;
    @(posedge clk_in) disable iff (!rst_n_in)
    auto_mode_in && below_thresh_in[1] && !hold_vec[1] |=> tgt_r[1] == DUTY_ZERO;
  endproperty
  a_floor2: assert property (p_floor2) else $error("output 2 floor wrong");

  property p_floor3;
    @(posedge clk_in) disable iff (!rst_n_in)
    auto_mode_in && below_thresh_in[2] && hold_vec[2] |=> tgt_r[2] == $past(min_duty_in3);
  endproperty
  a_floor3: assert property (p_floor3) else $error("output 3 floor wrong");

endmodule

// file: verilog/fan_ramp_pkg.sv
// Behaviour
// - Control bits 2:0 pick duty step per slot: 1,2,3,5,8,12,24,48.
// - With ramping on, output 1 duty walks toward each new target at that rate.
// - Slot length makes 33% to 100% take about 35 s slowest, 0.8 s fastest.
// - Ramping applies to output 1 only while control bit 3 is one.
// - Bit 4 high: sense inputs 2, 3 and 4 measured in step with output 3.
// - Bit 4 low: only sense inputs 3 and 4 follow output 3.
// - Auto mode below threshold: output 1 goes 0%, or minimum duty if bit 5 set.
// - Auto mode below threshold: output 2 goes 0%, or minimum duty if bit 6 set.
// - Auto mode below threshold: output 3 goes 0%, or minimum duty if bit 7 set.
package fan_ramp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int RATE_LSB = 0;
  localparam int EN_BIT = 3;
  localparam int SYNC_BIT = 4;
  localparam int HOLD1_BIT = 5;
  localparam int HOLD2_BIT = 6;
  localparam int HOLD3_BIT = 7;
  localparam int STAT_TARGET_LSB = 8;
  localparam int STAT_RAMP_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam int CLK_HZ = 125_000_000;
  // 170 unit steps of 205 ms cover 33% to 100% of an 8-bit duty in about 35 s
  localparam int SLOT_TIME_US = 205_000;
  localparam int SLOT_CYCLES = SLOT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int PWM_TICK_CYCLES = 16;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] RAMP_STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                             8'h08, 8'h0c, 8'h18, 8'h30};

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_RUN = 2'b01
  } ramp_state_t;

  function automatic logic [7:0] ramp_step(input logic [2:0] code);
    return RAMP_STEPS[code];
  endfunction

  function automatic logic [7:0] eff_target(input logic [7:0] target, input logic [7:0] min_duty,
                                            input logic hold, input logic auto_mode,
                                            input logic below);
    if (auto_mode && below) begin
      return hold ? min_duty : DUTY_ZERO;
    end
    return target;
  endfunction
endpackage
